//--- src/ascp_pkg.sv
// package for the serial configuration port of the converter
// assumes a single system clock domain; pins are synchronised in the top
package ascp_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [12:0] ADDR_PORT_SETUP  = 13'h0000;
    localparam logic [12:0] ADDR_BURST_LAST  = 13'h0002;
    localparam logic [12:0] ADDR_DIE_ID      = 13'h0008;
    localparam logic [12:0] ADDR_DIE_REV     = 13'h0009;
    localparam logic [12:0] ADDR_CONV_SEL    = 13'h0010;
    localparam logic [12:0] ADDR_OFS_LARGE   = 13'h0020;
    localparam logic [12:0] ADDR_OFS_SMALL   = 13'h0021;
    localparam logic [12:0] ADDR_GAIN_LARGE  = 13'h0022;
    localparam logic [12:0] ADDR_GAIN_MID    = 13'h0023;
    localparam logic [12:0] ADDR_GAIN_SMALL  = 13'h0024;
    localparam logic [12:0] ADDR_POWER_SEL   = 13'h0025;

    // ------------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------------
    localparam int          BIT_OUT_ENABLE   = 7;
    localparam int          BIT_LSB_FIRST    = 6;
    localparam int          BIT_SOFT_RESET   = 5;
    localparam logic [7:0]  PORT_SETUP_RST   = 8'h18;
    localparam logic [7:0]  BURST_LAST_RST   = 8'h00;
    localparam logic [7:0]  CONV_SEL_RST     = 8'h00;
    localparam logic [7:0]  TRIM_MID_RST     = 8'h80;
    localparam logic [7:0]  GAIN_LARGE_RST   = 8'h00;
    localparam logic [7:0]  POWER_SEL_RST    = 8'h00;
    localparam logic [7:0]  INDEX_ERROR_CODE = 8'hAD;
    localparam logic [2:0]  PWR_PIN          = 3'h0;
    localparam logic [2:0]  PWR_NORMAL       = 3'h1;
    localparam logic [2:0]  PWR_NAP          = 3'h2;
    localparam logic [2:0]  PWR_SLEEP        = 3'h4;
    localparam int          INSTR_BITS       = 16;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ASCP_PM_NORMAL,
        ASCP_PM_NAP,
        ASCP_PM_SLEEP
    } ascp_power_type;

    typedef struct packed {
        logic [7:0] offset_large;
        logic [7:0] offset_small;
        logic [3:0] gain_large;
        logic [7:0] gain_mid;
        logic [7:0] gain_small;
    } ascp_trim_type;

endpackage : ascp_pkg

//--- src/ascp_port.sv
// serial configuration slave with its register bank
// assumes serial pins come from another domain and are synchronised here
`timescale 1ns/1ps

module ascp_port #(
    parameter logic [7:0] DIE_ID_VALUE  = 8'h5A, // arbitrary value
    parameter logic [7:0] DIE_REV_VALUE = 8'h01, // arbitrary value
    parameter int         NUM_CONV      = 1
) (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_in,
    // serial pins
    input  wire logic                   serial_clock_in,
    input  wire logic                   chip_select_n_in,
    input  wire logic                   serial_data_in,
    output logic                        serial_data_out,
    output logic                        serial_data_oe_out,
    output logic                        serial_out_pin_out,
    // converter side
    input  wire logic [1:0]             power_state_pin_in,
    input  wire ascp_pkg::ascp_trim_type cal_trim_in,
    output ascp_pkg::ascp_trim_type     trim_out,
    output ascp_pkg::ascp_power_type    power_state_out
);
    import ascp_pkg::*;

    if (NUM_CONV < 1 || NUM_CONV > 8) begin : g_conv_check
        $error("NUM_CONV must be 1 to 8");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sclk_sync_r;
    logic [1:0] csn_sync_r;
    logic [1:0] sdi_sync_r;
    logic       sclk_last_r;
    logic       csn_last_r;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sclk_sync_r <= 2'h0;
            csn_sync_r  <= 2'h3;
            sdi_sync_r  <= 2'h0;
            sclk_last_r <= 1'b0;
            csn_last_r  <= 1'b1;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], serial_clock_in};
            csn_sync_r  <= {csn_sync_r[0], chip_select_n_in};
            sdi_sync_r  <= {sdi_sync_r[0], serial_data_in};
            sclk_last_r <= sclk_sync_r[1];
            csn_last_r  <= csn_sync_r[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    logic selected;
    assign sclk_rise = sclk_sync_r[1] & ~sclk_last_r;
    assign sclk_fall = ~sclk_sync_r[1] & sclk_last_r;
    assign csn_fall  = ~csn_sync_r[1] & csn_last_r;
    assign csn_rise  = csn_sync_r[1] & ~csn_last_r;
    assign selected  = ~csn_sync_r[1];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]    port_setup_r;
    logic [7:0]    burst_last_r;
    logic [7:0]    conv_sel_r;
    ascp_trim_type trim_r;
    logic [2:0]    power_sel_r;
    logic          lsb_first;
    assign lsb_first = port_setup_r[BIT_LSB_FIRST];

    // ------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE, ST_INSTR, ST_DATA, ST_DONE
    } ascp_state_type;
    ascp_state_type state_r;
    logic [15:0]    shift_r;
    logic [4:0]     bit_cnt_r;
    logic           is_read_r;
    logic [1:0]     count_r;
    logic [12:0]    addr_r;
    logic [2:0]     bytes_done_r;
    logic [7:0]     tx_r;
    logic           drive_r;
    logic           burst_end_r;

    logic [15:0] raw_word;
    logic [15:0] instr_word;
    logic [7:0]  data_byte;
    logic        byte_done;
    logic        write_strobe;
    logic [12:0] addr_step;
    logic [7:0]  read_value;
    logic        long_burst;

    // bit order: in lsb-first the word arrives reversed
    // the shifter keeps arrival order; only the decoded views are flipped
    always_comb begin
        raw_word   = {shift_r[14:0], sdi_sync_r[1]};
        instr_word = raw_word;
        data_byte  = raw_word[7:0];
        if (lsb_first) begin
            instr_word = {<<{raw_word}};
            data_byte  = {<<{raw_word[7:0]}};
        end
    end

    assign byte_done    = (state_r == ST_DATA) && sclk_rise
                          && bit_cnt_r == 5'd7;
    assign write_strobe = byte_done && !is_read_r;
    assign addr_step    = lsb_first ? addr_r - 13'd1 : addr_r + 13'd1;
    assign long_burst   = count_r == 2'h3;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r      <= ST_IDLE;
            shift_r      <= 16'h0000;
            bit_cnt_r    <= 5'd0;
            is_read_r    <= 1'b0;
            count_r      <= 2'h0;
            addr_r       <= 13'h0000;
            bytes_done_r <= 3'h0;
            burst_end_r  <= 1'b0;
        end else if (csn_rise) begin
            // short transfers may pause at a byte; long ones abort once a byte is done, else pause
            if (state_r == ST_DONE || (state_r == ST_DATA && long_burst
                && bytes_done_r != 3'h0)) begin
                state_r <= ST_IDLE;
            end else if (state_r == ST_DATA) begin
                bit_cnt_r <= 5'd0;
            end
        end else if (selected && sclk_rise) begin
            unique case (state_r)
                ST_IDLE, ST_INSTR: begin
                    shift_r   <= raw_word;
                    state_r   <= ST_INSTR;
                    bit_cnt_r <= bit_cnt_r + 5'd1;
                    if (bit_cnt_r == 5'(INSTR_BITS - 1)) begin
                        is_read_r    <= instr_word[15];
                        count_r      <= instr_word[14:13];
                        addr_r       <= instr_word[12:0];
                        bytes_done_r <= 3'h0;
                        burst_end_r  <= 1'b0;
                        bit_cnt_r    <= 5'd0;
                        state_r      <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    shift_r   <= raw_word;
                    bit_cnt_r <= bit_cnt_r + 5'd1;
                    if (byte_done) begin
                        bit_cnt_r <= 5'd0;
                        addr_r    <= addr_step;
                        if (bytes_done_r != 3'h7) begin
                            bytes_done_r <= bytes_done_r + 3'h1;
                        end
                        if (addr_r[7:0] == burst_last_r
                            && long_burst) begin
                            burst_end_r <= 1'b1;
                        end
                        if (!long_burst && bytes_done_r[1:0]
                            == count_r) begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: ;
            endcase
        end else if (!selected && state_r == ST_INSTR) begin
            state_r <= ST_INSTR;
        end
        if (csn_fall && state_r == ST_IDLE) begin
            bit_cnt_r <= 5'd0;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic indexed;
    logic index_ok;
    assign indexed  = addr_r >= ADDR_OFS_LARGE && addr_r <= ADDR_POWER_SEL;
    assign index_ok = conv_sel_r[0];

    always_comb begin
        read_value = 8'h00;
        unique case (addr_r)
            ADDR_PORT_SETUP: read_value = port_setup_r;
            ADDR_BURST_LAST: read_value = burst_last_r;
            ADDR_DIE_ID:     read_value = DIE_ID_VALUE;
            ADDR_DIE_REV:    read_value = DIE_REV_VALUE;
            ADDR_CONV_SEL:   read_value = conv_sel_r;
            ADDR_OFS_LARGE:  read_value = trim_r.offset_large;
            ADDR_OFS_SMALL:  read_value = trim_r.offset_small;
            ADDR_GAIN_LARGE: read_value = {4'h0, trim_r.gain_large};
            ADDR_GAIN_MID:   read_value = trim_r.gain_mid;
            ADDR_GAIN_SMALL: read_value = trim_r.gain_small;
            ADDR_POWER_SEL:  read_value = {5'h00, power_sel_r};
            default:         read_value = 8'h00;
        endcase
        if (indexed && !index_ok) begin
            read_value = INDEX_ERROR_CODE;
        end
    end

    // output changes on falling serial clock; loads at byte start
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tx_r    <= 8'h00;
            drive_r <= 1'b0;
        end else if (!selected || state_r != ST_DATA || !is_read_r
                     || burst_end_r) begin
            drive_r <= 1'b0;
            tx_r    <= read_value;
        end else if (sclk_fall) begin
            drive_r <= 1'b1;
            if (bit_cnt_r == 5'd0) begin
                tx_r <= read_value;
            end else begin
                tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
            end
        end
    end

    logic tx_bit;
    assign tx_bit = lsb_first ? tx_r[0] : tx_r[7];

    always_comb begin
        serial_data_out    = tx_bit;
        serial_data_oe_out = drive_r && !port_setup_r[BIT_OUT_ENABLE];
        serial_out_pin_out = port_setup_r[BIT_OUT_ENABLE] ? tx_bit : 1'b1;
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    logic wr_hit;
    logic soft_reset;
    assign wr_hit     = write_strobe && !burst_end_r;
    assign soft_reset = wr_hit && addr_r == ADDR_PORT_SETUP
                        && data_byte[BIT_SOFT_RESET];

    always_ff @(posedge mclk_in) begin
        if (rst_in || soft_reset) begin
            port_setup_r <= PORT_SETUP_RST;
            burst_last_r <= BURST_LAST_RST;
            conv_sel_r   <= CONV_SEL_RST;
        end else if (wr_hit) begin
            unique case (addr_r)
                ADDR_PORT_SETUP: port_setup_r <= data_byte;
                ADDR_BURST_LAST: burst_last_r <= data_byte;
                ADDR_CONV_SEL:   conv_sel_r   <= data_byte;
                default:         ;
            endcase
        end
    end

    logic rst_last_r;
    always_ff @(posedge mclk_in) begin
        rst_last_r <= rst_in;
    end

    // trims load calibration results the cycle after reset is released; not touched by soft reset
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            trim_r <= '{TRIM_MID_RST, TRIM_MID_RST, GAIN_LARGE_RST[3:0],
                        TRIM_MID_RST, TRIM_MID_RST};
        end else if (rst_last_r) begin
            trim_r <= cal_trim_in;
        end else if (wr_hit && index_ok) begin
            unique case (addr_r)
                ADDR_OFS_LARGE:  trim_r.offset_large <= data_byte;
                ADDR_OFS_SMALL:  trim_r.offset_small <= data_byte;
                ADDR_GAIN_LARGE: trim_r.gain_large   <= data_byte[3:0];
                ADDR_GAIN_MID:   trim_r.gain_mid     <= data_byte;
                ADDR_GAIN_SMALL: trim_r.gain_small   <= data_byte;
                default:         ;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            power_sel_r <= POWER_SEL_RST[2:0];
        end else if (wr_hit && index_ok && addr_r == ADDR_POWER_SEL) begin
            power_sel_r <= data_byte[2:0];
        end
    end

    // ------------------------------------------------------------------
    // converter side outputs
    // ------------------------------------------------------------------
    assign trim_out = trim_r;

    logic [1:0] pin_sync_r [2];
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_sync_r[0] <= 2'h0;
            pin_sync_r[1] <= 2'h0;
        end else begin
            pin_sync_r[0] <= power_state_pin_in;
            pin_sync_r[1] <= pin_sync_r[0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            power_state_out <= ASCP_PM_NORMAL;
        end else begin
            unique case (power_sel_r)
                PWR_NAP:    power_state_out <= ASCP_PM_NAP;
                PWR_SLEEP:  power_state_out <= ASCP_PM_SLEEP;
                PWR_NORMAL: power_state_out <= ASCP_PM_NORMAL;
                default: begin
                    unique case (pin_sync_r[1])
                        2'h1:    power_state_out <= ASCP_PM_SLEEP;
                        2'h2:    power_state_out <= ASCP_PM_NAP;
                        default: power_state_out <= ASCP_PM_NORMAL;
                    endcase
                end
            endcase
        end
    end

endmodule : ascp_port

//--- testbench/ascp_port_checker.sv
// assertions on the serial configuration port's pins and trims
// assumes one mclk domain; bound to every port instance below
`timescale 1ns/1ps
module ascp_port_checker (
    // clock and reset
    input wire logic                    mclk_in,
    input wire logic                    rst_in,
    // pins and trims
    input wire logic                    serial_clock_in,
    input wire logic                    chip_select_n_in,
    input wire logic                    serial_data_out,
    input wire logic                    serial_data_oe_out,
    input wire logic                    serial_out_pin_out,
    input wire ascp_pkg::ascp_trim_type cal_trim_in,
    input wire ascp_pkg::ascp_trim_type trim_out
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    reset_idle_a: assert property ($fell(rst_in) |->
        serial_out_pin_out && !serial_data_oe_out) else $error("not idle");
    trim_load_a: assert property ($fell(rst_in) |->
        ##[1:2] trim_out == cal_trim_in) else $error("trims not loaded");
    pin_quiet_a: assert property (serial_data_oe_out |->
        serial_out_pin_out) else $error("output pin busy in three-wire");
    oe_select_a: assert property ($rose(serial_data_oe_out) |->
        !chip_select_n_in) else $error("line driven while deselected");
    oe_release_a: assert property ($rose(chip_select_n_in) |->
        ##[1:5] !serial_data_oe_out) else $error("line not released");
    // the answer lands about 3 mclk after a falling serial edge
    oe_on_low_a: assert property ($rose(serial_data_oe_out) |->
        !serial_clock_in) else $error("line taken on high clock");
    data_hold_a: assert property (serial_data_oe_out &&
        $past(serial_data_oe_out) && serial_clock_in && $past(serial_clock_in)
        |-> $stable(serial_data_out)) else $error("read bit moved");
    trim_hold_a: assert property (chip_select_n_in[*6] ##0
        !$past(rst_in, 8) |-> $stable(trim_out)) else $error("trim moved");

    cover property ($rose(serial_data_oe_out));
    cover property ($changed(trim_out));
    cover property ($rose(chip_select_n_in) && serial_data_oe_out);
endmodule : ascp_port_checker

bind ascp_port ascp_port_checker chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .serial_clock_in(serial_clock_in),
    .chip_select_n_in(chip_select_n_in), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out),
    .serial_out_pin_out(serial_out_pin_out), .cal_trim_in(cal_trim_in),
    .trim_out(trim_out)
);

//--- testbench/ascp_master_model.sv
// serial master model driving the configuration port's pins
// assumes the bench sets lsb, four and wbuf before calling frame,
// and calls frame on an mclk rising edge
`timescale 1ns/1ps
module ascp_master_model (
    // pins towards the port
    output logic      serial_clock_out,
    output logic      chip_select_n_out,
    output logic      line_out,
    input wire logic  dev_data_in,
    input wire logic  dev_oe_in,
    input wire logic  pin4_in
);
    // ------------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------------
    logic [7:0] wbuf [8];
    logic [7:0] rbuf [8];
    logic       lsb    = 1'b0;
    logic       four   = 1'b0;
    logic       mst_d  = 1'b0;
    logic       mst_oe = 1'b1;

    // a released line shows the inverse, so stale data never matches
    assign line_out = dev_oe_in ? dev_data_in : (mst_oe ? mst_d : ~mst_d);

    initial begin
        serial_clock_out = 1'b0;
        chip_select_n_out = 1'b1;
    end

    // 320 ns serial period, far below the sample-rate limits
    // read bit is taken just before the rise, well after it settles
    task automatic clk_bit(input logic d, output logic q);
        mst_d = d;
        #140 q = four ? pin4_in : line_out;
        #20 serial_clock_out = 1'b1;
        #160 serial_clock_out = 1'b0;
    endtask : clk_bit

    // the mclk runs throughout, so access is always allowed
    task automatic frame(input logic [15:0] ins, input int n);
        logic q;
        int   idx;
        mst_oe = 1'b1;
        // pins move 10 ns after an mclk edge, never on it
        #10 chip_select_n_out = 1'b0;
        for (int i = 0; i < 16; i++) begin
            idx = lsb ? i : 15 - i;
            clk_bit(ins[idx], q);
        end
        mst_oe = !ins[15];
        for (int b = 0; b < n; b++) begin
            for (int k = 0; k < 8; k++) begin
                idx = lsb ? k : 7 - k;
                clk_bit(wbuf[b][idx], q);
                rbuf[b][idx] = q;
            end
        end
        #160 chip_select_n_out = 1'b1;
        mst_oe = 1'b1;
        mst_d = ~mst_d;
        #310;
    endtask : frame
endmodule : ascp_master_model

//--- testbench/tb.sv
// self-checking bench for the serial configuration port
// assumes the master model in ascp_master_model.sv
`timescale 1ns/1ps
module tb;
    import ascp_pkg::*;
    // ------------------------------------------------------------------
    // signals and helpers
    // ------------------------------------------------------------------
    localparam logic [7:0] ID_V  = 8'hA7; // arbitrary value
    localparam logic [7:0] REV_V = 8'h02; // arbitrary value
    localparam logic [7:0] CODES [3] = '{8'h00, 8'h80, 8'hFF};
    logic           mclk_in = 1'b0;
    logic           rst_in  = 1'b1;
    logic [1:0]     pin_r   = 2'h0;
    ascp_trim_type  cal_r   = '0;
    ascp_trim_type  exp_t;
    ascp_trim_type  trim;
    ascp_power_type pwr;
    wire            sclk, csn, line;
    logic           serial_out_pin, oe, pin4;
    int             n_fail = 0;
    int             cmp_count = 0;
    int             cyc = 0;

    initial forever #20 mclk_in = ~mclk_in;

    ascp_port #(.DIE_ID_VALUE(ID_V), .DIE_REV_VALUE(REV_V), .NUM_CONV(1)) uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .serial_clock_in(sclk),
        .chip_select_n_in(csn), .serial_data_in(line),
        .serial_data_out(serial_out_pin), .serial_data_oe_out(oe),
        .serial_out_pin_out(pin4), .power_state_pin_in(pin_r),
        .cal_trim_in(cal_r), .trim_out(trim), .power_state_out(pwr));
    ascp_master_model m (.serial_clock_out(sclk), .chip_select_n_out(csn),
        .line_out(line), .dev_data_in(serial_out_pin), .dev_oe_in(oe), .pin4_in(pin4));

    task automatic fail(input string s);
        n_fail++;
        $display("unexpected at %0t: %s", $time, s);
    endtask : fail
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
    endtask : cmp8
    task automatic cmpt(input ascp_trim_type got, input ascp_trim_type exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("trims %h want %h", got, exp));
    endtask : cmpt
    task automatic cmpp(input ascp_power_type got, input ascp_power_type exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("power %0d want %0d", got, exp));
    endtask : cmpp
    function automatic logic [7:0] setup_val(input logic o, l, s);
        return {o, l, s, 1'b1, 1'b1, s, l, o};
    endfunction : setup_val
    function automatic ascp_power_type pin_pwr(input logic [1:0] p);
        return p == 2'h1 ? ASCP_PM_SLEEP
             : (p == 2'h2 ? ASCP_PM_NAP : ASCP_PM_NORMAL);
    endfunction : pin_pwr
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        m.wbuf[0] = d;
        m.frame({1'b0, 2'h0, a}, 1);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [1:0] c, input int n);
        m.frame({1'b1, c, a}, n);
    endtask : rd
    task automatic pm_seq(input logic [7:0] v);
        wr(ADDR_CONV_SEL, 8'h01);
        wr(ADDR_POWER_SEL, v);
        wr(ADDR_CONV_SEL, 8'h02);
        wr(ADDR_POWER_SEL, v);
    endtask : pm_seq
    task automatic results;
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 30000) begin
            fail("timeout");
            results;
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h5E0D6232));
        pin_r <= 2'h1;
        cal_r <= ascp_trim_type'(36'({$urandom(), $urandom()}));
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        exp_t = cal_r;
        cmpt(trim, exp_t);
        rd(ADDR_PORT_SETUP, 2'h0, 1);
        cmp8(m.rbuf[0], setup_val(1'b0, 1'b0, 1'b0));
        rd(ADDR_DIE_ID, 2'h1, 2);
        cmp8(m.rbuf[0], ID_V);
        cmp8(m.rbuf[1], REV_V);
        rd(ADDR_CONV_SEL, 2'h0, 1);
        cmp8(m.rbuf[0], 8'h00);
        rd(ADDR_OFS_LARGE, 2'h0, 1);
        cmp8(m.rbuf[0], INDEX_ERROR_CODE);
        wr(ADDR_OFS_LARGE, ~exp_t.offset_large);
        cmpt(trim, exp_t);
        wr(ADDR_CONV_SEL, 8'h01);
        for (int i = 0; i < 5; i++) m.wbuf[i] = 8'($urandom());
        m.frame({1'b0, 2'h3, ADDR_OFS_LARGE}, 5);
        exp_t = {m.wbuf[0], m.wbuf[1], m.wbuf[2][3:0], m.wbuf[3], m.wbuf[4]};
        cmpt(trim, exp_t);
        // a fourth byte on a three-byte count must not reach power mode
        for (int i = 0; i < 3; i++) m.wbuf[i] = 8'($urandom());
        m.wbuf[3] = 8'h02;
        m.frame({1'b0, 2'h2, ADDR_GAIN_LARGE}, 4);
        exp_t.gain_large = m.wbuf[0][3:0];
        exp_t.gain_mid = m.wbuf[1];
        exp_t.gain_small = m.wbuf[2];
        cmpt(trim, exp_t);
        cmpp(pwr, pin_pwr(pin_r));
        m.wbuf[0] = 8'($urandom());
        m.frame({1'b0, 2'h3, ADDR_GAIN_MID}, 1);
        exp_t.gain_mid = m.wbuf[0];
        cmpt(trim, exp_t);
        exp_t.gain_small = 8'($urandom());
        wr(ADDR_GAIN_SMALL, exp_t.gain_small);
        cmpt(trim, exp_t);
        for (int i = 0; i < 3; i++) begin
            exp_t.offset_large = CODES[i];
            wr(ADDR_OFS_LARGE, CODES[i]);
            cmpt(trim, exp_t);
        end
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_OFS_SMALL, 2'h0, 1);
            cmp8(m.rbuf[0], exp_t.offset_small);
            exp_t.offset_small += ($urandom() % 2) ? 8'h01 : 8'hFF;
            wr(ADDR_OFS_SMALL, exp_t.offset_small);
            cmpt(trim, exp_t);
        end
        pm_seq(8'h02);
        cmpp(pwr, ASCP_PM_NAP);
        pm_seq(8'h01);
        cmpp(pwr, ASCP_PM_NORMAL);
        wr(ADDR_CONV_SEL, 8'h01);
        wr(ADDR_POWER_SEL, 8'h04);
        cmpp(pwr, ASCP_PM_SLEEP);
        wr(ADDR_POWER_SEL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            pin_r <= 2'($urandom() % 3);
            repeat (8) @(posedge mclk_in);
            cmpp(pwr, pin_pwr(pin_r));
        end
        wr(ADDR_POWER_SEL, 8'h02);
        wr(ADDR_BURST_LAST, 8'h21);
        for (int i = 0; i < 3; i++) m.wbuf[i] = 8'($urandom());
        m.frame({1'b0, 2'h3, ADDR_OFS_LARGE}, 3);
        exp_t.offset_large = m.wbuf[0];
        exp_t.offset_small = m.wbuf[1];
        cmpt(trim, exp_t);
        wr(ADDR_PORT_SETUP, setup_val(1'b0, 1'b0, 1'b1));
        rd(ADDR_CONV_SEL, 2'h0, 1);
        cmp8(m.rbuf[0], CONV_SEL_RST);
        rd(ADDR_PORT_SETUP, 2'h0, 1);
        cmp8(m.rbuf[0], setup_val(1'b0, 1'b0, 1'b0));
        cmpp(pwr, ASCP_PM_NAP);
        cmpt(trim, exp_t);
        wr(ADDR_PORT_SETUP, setup_val(1'b0, 1'b1, 1'b0));
        m.lsb = 1'b1;
        rd(ADDR_DIE_REV, 2'h1, 2);
        cmp8(m.rbuf[0], REV_V);
        cmp8(m.rbuf[1], ID_V);
        wr(ADDR_PORT_SETUP, setup_val(1'b0, 1'b0, 1'b0));
        m.lsb = 1'b0;
        wr(ADDR_PORT_SETUP, setup_val(1'b1, 1'b0, 1'b0));
        m.four = 1'b1;
        rd(ADDR_DIE_ID, 2'h0, 1);
        cmp8(m.rbuf[0], ID_V);
        results;
    end
endmodule : tb
